// ==== core/dcic_cfg.svh ====
// Overview of operation
// RULE1 - two identical channels, each picks timer A or timer B as capture source
// RULE2 - software enables the channel input select bit and sets the pin as input first
// RULE3 - filtered rising edge stores count in latch x0, falling edge in latch x1
// RULE4 - writing one to a latch's software trigger bit copies the current count there
// RULE5 - software trigger bits always read back as zero
// RULE6 - per-channel status bit tells which latch holds the newest capture
// RULE7 - per-channel edge select bits decide which edges raise the interrupt request
// RULE8 - both latches capture on their edges whatever the edge select holds
// RULE9 - noise filter accepts a new level after four equal consecutive samples
// RULE10 - per-channel filter clock select bits choose the filter sampling rate
// RULE11 - for stop-mode wakeup software sets filter select to 00, stopping the filter
// RULE12 - software sets read pointer, then reads low and high byte of that latch
// RULE13 - software reads twice and compares, since a capture may split the bytes
// RULE14 - timer A is not chosen while it counts the on-chip oscillator
// RULE15 - timer B not chosen when main oscillator, A underflow and oscillator chain holds
// RULE16 - status bit may be arbitrary on simultaneous triggers of one channel
// RULE17 - rewriting edge or filter select may raise the interrupt request spuriously
// RULE18 - software masks the interrupt, changes settings, clears flag, then unmasks
// RULE19 - edges come from filtered input; capture in the period the level changes
// RULE20 - each latch holds sixteen bits until the next capture into it
// Purpose: constants of the dual channel input capture unit
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:   included by bare name
`ifndef DCIC_CFG_SVH
`define DCIC_CFG_SVH

// ==========================================================
// register byte offsets
`define DCIC_ADR_MODE    8'h00
`define DCIC_ADR_SWTRIG  8'h04
`define DCIC_ADR_RDPTR   8'h08
`define DCIC_ADR_CAPLO   8'h0C
`define DCIC_ADR_CAPHI   8'h10
`define DCIC_ADR_STATUS  8'h14

// ==========================================================
// mode register: one byte per channel
`define DCIC_CH_STRIDE   8
`define DCIC_CFG_W       6
`define DCIC_F_EDGE      1
`define DCIC_SET_W       4
`define DCIC_MODE_RST    16'h0000
`define DCIC_RDPTR_RST   2'h0

// ==========================================================
// status register fields
`define DCIC_F_LEVEL     4

// ==========================================================
// encodings and sampling dividers
`define DCIC_EDGE_NONE   2'h0
`define DCIC_EDGE_RISE   2'h1
`define DCIC_EDGE_FALL   2'h2
`define DCIC_EDGE_BOTH   2'h3
`define DCIC_FILT_STOP   2'h0
`define DCIC_FILT_FAST   2'h1
`define DCIC_FILT_MID    2'h2
`define DCIC_FILT_SLOW   2'h3
`define DCIC_DIV_MID     5'h07
`define DCIC_DIV_SLOW    5'h1F
`define DCIC_FILT_LAST   2'h3

`endif

// ==== core/dcic_pkg.sv ====
// Purpose: types of the dual channel input capture unit
// Assumes: nothing
// Notes:   constants live in dcic_cfg.svh
package dcic_pkg;

  typedef enum logic [1:0] {
    DCIC_WB_IDLE = 2'b00,
    DCIC_WB_ACK  = 2'b01
  } dcic_wb_state_type;

  typedef struct packed {
    logic       port_en;
    logic [1:0] filt_sel;
    logic [1:0] edge_sel;
    logic       src_b;
  } dcic_chcfg_type;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } dcic_edge_type;

  typedef logic [3:0][15:0] dcic_latch_arr_type;

endpackage : dcic_pkg

// ==== core/dcic_filter.sv ====
// Purpose: four-sample noise filter and edge detector of one channel
// Assumes: raw input synchronous to clk_i
// Notes:   bypass passes the input straight through
`timescale 1ns/1ps
`default_nettype none
`include "dcic_cfg.svh"
module dcic_filter (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               sample_en_i,
  input  wire logic               bypass_i,
  input  wire logic               raw_i,
  output var  dcic_pkg::dcic_edge_type edge_o
);
  import dcic_pkg::*;

  logic       level_q;
  logic       level_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       differ;

  assign differ  = raw_i ^ level_q;
  assign level_d = bypass_i ? raw_i :
                   (sample_en_i && differ && cnt_q == `DCIC_FILT_LAST) ? raw_i : level_q; // RULE9
  assign cnt_d   = (bypass_i || !differ) ? 2'h0 :
                   !sample_en_i ? cnt_q :
                   (cnt_q == `DCIC_FILT_LAST) ? 2'h0 : cnt_q + 2'h1;
  assign edge_o.level = level_q;
  assign edge_o.rise  = level_d & ~level_q; // RULE19
  assign edge_o.fall  = ~level_d & level_q; // RULE19

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_q <= 1'b0;
      cnt_q   <= 2'h0;
    end else begin
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_filt_accept;
    (!bypass_i && sample_en_i && differ && cnt_q == 2'h3) |=> (level_q == $past(raw_i));
  endproperty
  a_filt_accept: assert property (p_filt_accept) else $error("filter missed fourth sample"); // RULE9

  property p_filt_hold;
    (!$past(bypass_i) && level_q != $past(level_q)) |-> ($past(cnt_q) == 2'h3 && $past(sample_en_i));
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter changed level too early"); // RULE9

endmodule : dcic_filter
`default_nettype wire

// ==== core/dcic_latch_mem.sv ====
// Purpose: four sixteen-bit capture latches with registered read
// Assumes: one write enable per latch
// Notes:   read data follows raddr_i one cycle later
`timescale 1ns/1ps
`default_nettype none
module dcic_latch_mem (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic [3:0]                   we_i,
  input  wire dcic_pkg::dcic_latch_arr_type wdata_i,
  input  wire logic [1:0]                   raddr_i,
  output logic      [15:0]                  rdata_o
);
  import dcic_pkg::*;

  dcic_latch_arr_type mem_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_word
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mem_q[gi] <= 16'h0000;
        end else if (we_i[gi]) begin
          mem_q[gi] <= wdata_i[gi]; // RULE20
        end
      end

      property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i) !we_i[gi] |=> (mem_q[gi] == $past(mem_q[gi]));
      endproperty
      a_hold: assert property (p_hold) else $error("latch changed without capture"); // RULE20
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule : dcic_latch_mem
`default_nettype wire

// ==== core/dcic_top.sv ====
// Purpose: dual channel input capture with Wishbone register access
// Assumes: timer counts and capture pins synchronous to clk_sys_i
// Notes:   interrupt requests leave as one-cycle pulses
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dcic_cfg.svh"
module dcic_top (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] timer_a_i,
  input  wire logic [15:0] timer_b_i,
  input  wire logic        capture_input_0_i,
  input  wire logic        capture_input_1_i,
  output logic      [1:0]  capture_irq_o
);
  import dcic_pkg::*;

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // decode helpers
  function automatic logic adr_is(input logic [7:0] adr, input logic [7:0] off);
    adr_is = (adr[7:2] == off[7:2]);
  endfunction : adr_is

  function automatic logic tick_sel(input logic [1:0] sel, input logic [4:0] cnt);
    case (sel)
      `DCIC_FILT_FAST: tick_sel = 1'b1;
      `DCIC_FILT_MID:  tick_sel = ((cnt & `DCIC_DIV_MID) == `DCIC_DIV_MID);
      `DCIC_FILT_SLOW: tick_sel = (cnt == `DCIC_DIV_SLOW);
      default:         tick_sel = 1'b0;
    endcase
  endfunction : tick_sel

  // ==========================================================
  // wishbone slave
  dcic_wb_state_type state_q;
  logic [31:0]       dat_q;
  logic [31:0]       rd_mux;
  logic              req;
  logic              wr_acc;
  logic              hit_mode;
  logic              hit_swtrig;
  logic              hit_rdptr;
  logic              hit_caplo;
  logic              hit_caphi;
  logic              hit_status;

  assign req        = wb_cyc_i & wb_stb_i;
  assign wr_acc     = (state_q == DCIC_WB_ACK) & req & wb_we_i;
  assign hit_mode   = adr_is(wb_adr_i, `DCIC_ADR_MODE);
  assign hit_swtrig = adr_is(wb_adr_i, `DCIC_ADR_SWTRIG);
  assign hit_rdptr  = adr_is(wb_adr_i, `DCIC_ADR_RDPTR);
  assign hit_caplo  = adr_is(wb_adr_i, `DCIC_ADR_CAPLO);
  assign hit_caphi  = adr_is(wb_adr_i, `DCIC_ADR_CAPHI);
  assign hit_status = adr_is(wb_adr_i, `DCIC_ADR_STATUS);
  assign wb_ack_o   = (state_q == DCIC_WB_ACK);
  assign wb_dat_o   = dat_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DCIC_WB_IDLE;
      dat_q   <= 32'h00000000;
    end else begin
      case (state_q)
        DCIC_WB_IDLE: begin
          if (req) begin
            state_q <= DCIC_WB_ACK;
            dat_q   <= rd_mux;
          end
        end
        DCIC_WB_ACK: begin
          state_q <= DCIC_WB_IDLE;
        end
        default: begin
          state_q <= DCIC_WB_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // control registers
  logic [15:0] mode_q;
  logic [1:0]  rdptr_q;
  logic [1:0]  latest_q;
  logic [1:0]  irq_q;
  logic [1:0]  latest_d;
  logic [1:0]  irq_d;
  logic [1:0]  level;
  logic [15:0] mem_rd;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= `DCIC_MODE_RST;
      rdptr_q <= `DCIC_RDPTR_RST;
    end else begin
      if (wr_acc && hit_mode && wb_sel_i[0]) begin
        mode_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_acc && hit_mode && wb_sel_i[1]) begin
        mode_q[15:8] <= wb_dat_i[15:8];
      end
      if (wr_acc && hit_rdptr && wb_sel_i[0]) begin
        rdptr_q <= wb_dat_i[1:0]; // RULE12
      end
    end
  end

  // swtrig reads zero; unmapped reads zero
  assign rd_mux = hit_mode   ? {16'h0000, mode_q} :
                  hit_rdptr  ? {30'h00000000, rdptr_q} :
                  hit_caplo  ? {24'h000000, mem_rd[7:0]} :   // RULE12
                  hit_caphi  ? {24'h000000, mem_rd[15:8]} :  // RULE12
                  hit_status ? {26'h0000000, level, 2'b00, latest_q} :
                  32'h00000000; // RULE5

  // ==========================================================
  // channels
  logic [4:0]         div_q;
  logic [3:0]         lat_we;
  dcic_latch_arr_type lat_wdata;
  logic [1:0]         pins;
  logic [1:0]         rise;
  logic [1:0]         fall;
  logic [1:0]         touch;
  dcic_chcfg_type     cfg [2];

  assign pins = {capture_input_1_i, capture_input_0_i};

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      dcic_edge_type edg;
      logic [15:0]   count;
      logic [1:0]    sw;

      assign cfg[ch] = dcic_chcfg_type'(mode_q[ch*`DCIC_CH_STRIDE +: `DCIC_CFG_W]);
      assign count   = cfg[ch].src_b ? timer_b_i : timer_a_i; // RULE1

      dcic_filter u_filter (
        .clk_i       (clk_sys_i),
        .rst_n_i     (rst_n),
        .sample_en_i (tick_sel(cfg[ch].filt_sel, div_q)),          // RULE10
        .bypass_i    (cfg[ch].filt_sel == `DCIC_FILT_STOP),
        .raw_i       (pins[ch] & cfg[ch].port_en),
        .edge_o      (edg)
      );

      assign rise[ch]  = edg.rise;
      assign fall[ch]  = edg.fall;
      assign level[ch] = edg.level;
      assign sw        = (wr_acc && hit_swtrig && wb_sel_i[0]) ? wb_dat_i[ch*2 +: 2] : 2'b00;

      assign lat_we[ch*2]      = edg.rise | sw[0];  // RULE3 RULE4 RULE8
      assign lat_we[ch*2+1]    = edg.fall | sw[1];  // RULE3 RULE4 RULE8
      assign lat_wdata[ch*2]   = count;
      assign lat_wdata[ch*2+1] = count;

      // simultaneous triggers resolve toward the earlier-listed source
      assign latest_d[ch] = edg.rise ? 1'b0 :
                            edg.fall ? 1'b1 :
                            sw[1]    ? 1'b1 :
                            sw[0]    ? 1'b0 : latest_q[ch]; // RULE6 RULE16

      assign touch[ch] = wr_acc && hit_mode && wb_sel_i[ch] &&
                         (wb_dat_i[ch*`DCIC_CH_STRIDE+`DCIC_F_EDGE +: `DCIC_SET_W] !=
                          mode_q[ch*`DCIC_CH_STRIDE+`DCIC_F_EDGE +: `DCIC_SET_W]);
      assign irq_d[ch] = (cfg[ch].edge_sel[0] & edg.rise) |
                         (cfg[ch].edge_sel[1] & edg.fall) | touch[ch]; // RULE7 RULE17
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      latest_q <= 2'b00;
      irq_q    <= 2'b00;
    end else begin
      latest_q <= latest_d;
      irq_q    <= irq_d;
    end
  end
  assign capture_irq_o = irq_q;

  dcic_latch_mem u_mem (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .we_i    (lat_we),
    .wdata_i (lat_wdata),
    .raddr_i (rdptr_q),
    .rdata_o (mem_rd)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  sequence s_read_start(logic hit);
    !wb_ack_o && req && !wb_we_i && hit;
  endsequence

  sequence s_write(logic hit);
    wr_acc && hit;
  endsequence

  property p_swtrig_zero;
    s_read_start(hit_swtrig) |=> (wb_ack_o && wb_dat_o == 32'h00000000);
  endproperty
  a_swtrig_zero: assert property (p_swtrig_zero) else $error("trigger register read nonzero"); // RULE5

  property p_caplo;
    s_read_start(hit_caplo) |=> (wb_ack_o && wb_dat_o[7:0] == $past(mem_rd[7:0]) && wb_dat_o[31:8] == 24'h000000);
  endproperty
  a_caplo: assert property (p_caplo) else $error("low byte read mismatch"); // RULE12

  property p_caphi;
    s_read_start(hit_caphi) |=> (wb_ack_o && wb_dat_o[7:0] == $past(mem_rd[15:8]));
  endproperty
  a_caphi: assert property (p_caphi) else $error("high byte read mismatch"); // RULE12

  property p_rise_cap;
    rise[0] |=> (u_mem.mem_q[0] == $past(cfg[0].src_b ? timer_b_i : timer_a_i));
  endproperty
  a_rise_cap: assert property (p_rise_cap) else $error("rising edge not captured"); // RULE3 RULE1

  property p_fall_cap_noirq;
    (fall[1] && cfg[1].edge_sel == `DCIC_EDGE_NONE) |-> (lat_we[3] && (!irq_d[1] || touch[1]));
  endproperty
  a_fall_cap_noirq: assert property (p_fall_cap_noirq) else $error("falling capture gated by edge select"); // RULE8

  property p_sw_trig;
    (wr_acc && hit_swtrig && wb_sel_i[0] && wb_dat_i[2]) |-> (lat_we[2] && lat_wdata[2] == (cfg[1].src_b ? timer_b_i : timer_a_i));
  endproperty
  a_sw_trig: assert property (p_sw_trig) else $error("software trigger lost"); // RULE4

  property p_latest;
    (rise[0] |=> !latest_q[0]) and (fall[0] |=> latest_q[0]);
  endproperty
  a_latest: assert property (p_latest) else $error("latest latch bit wrong"); // RULE6

  property p_irq_cause;
    capture_irq_o[0] |-> $past((cfg[0].edge_sel[0] && rise[0]) || (cfg[0].edge_sel[1] && fall[0]) || touch[0]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause"); // RULE7

  property p_irq_pulse;
    (cfg[0].edge_sel == `DCIC_EDGE_BOTH && (rise[0] || fall[0])) |=> capture_irq_o[0];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("selected edge gave no interrupt"); // RULE7

  property p_touch;
    touch[1] |=> capture_irq_o[1];
  endproperty
  a_touch: assert property (p_touch) else $error("settings rewrite gave no request"); // RULE17

  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

  // ==========================================================
  // register, capture, interrupt and filter checks
  property p_ack_answer;
    (req && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");

  property p_mode_wr;
    s_write(hit_mode && wb_sel_i[0]) |=> (mode_q[7:0] == $past(wb_dat_i[7:0]));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode byte not written"); // RULE10

  property p_rdptr_wr;
    s_write(hit_rdptr && wb_sel_i[0]) |=> (rdptr_q == $past(wb_dat_i[1:0]));
  endproperty
  a_rdptr_wr: assert property (p_rdptr_wr) else $error("read pointer not written"); // RULE12

  property p_status;
    s_read_start(hit_status) |=> (wb_dat_o == {26'h0000000, $past(level), 2'b00, $past(latest_q)});
  endproperty
  a_status: assert property (p_status) else $error("status read mismatch"); // RULE6

  property p_fall_cap;
    fall[1] |=> (u_mem.mem_q[3] == $past(cfg[1].src_b ? timer_b_i : timer_a_i));
  endproperty
  a_fall_cap: assert property (p_fall_cap) else $error("falling edge not captured"); // RULE3

  property p_sw_lat1;
    s_write(hit_swtrig && wb_sel_i[0] && wb_dat_i[1]) |=>
      (u_mem.mem_q[1] == $past(cfg[0].src_b ? timer_b_i : timer_a_i));
  endproperty
  a_sw_lat1: assert property (p_sw_lat1) else $error("software trigger missed latch"); // RULE4

  property p_latest_ch1;
    (rise[1] |=> !latest_q[1]) and (fall[1] |=> latest_q[1]);
  endproperty
  a_latest_ch1: assert property (p_latest_ch1) else $error("latest latch bit wrong"); // RULE6

  property p_irq_quiet;
    (cfg[1].edge_sel == `DCIC_EDGE_NONE && !touch[1]) |=> !capture_irq_o[1];
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt with no edge selected"); // RULE7

  property p_irq_rise_only;
    (cfg[0].edge_sel == `DCIC_EDGE_RISE && fall[0] && !touch[0]) |=> !capture_irq_o[0];
  endproperty
  a_irq_rise_only: assert property (p_irq_rise_only) else $error("falling edge raised interrupt"); // RULE7

  property p_filter_stop;
    (cfg[0].filt_sel == `DCIC_FILT_STOP) |=> (level[0] == $past(pins[0] & cfg[0].port_en));
  endproperty
  a_filter_stop: assert property (p_filter_stop) else $error("stopped filter did not pass input"); // RULE10

endmodule : dcic_top
`default_nettype wire

// ==== core/dcic_top_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/dcic_pin_model.sv ====
// Purpose: far-side model driving the two capture pins
// Assumes: pin level requests come from the bench
// Notes:   a level change may bounce for bounce_i cycles before settling
`timescale 1ns/1ps
`default_nettype none
module dcic_pin_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] level_i,
  input  wire logic [3:0] bounce_i,
  output logic      [1:0] pin_o
);
  logic [1:0] settled_q;
  logic [3:0] cnt_q [2];

  initial begin
    settled_q = 2'h0;
    pin_o     = 2'h0;
    cnt_q[0]  = 4'h0;
    cnt_q[1]  = 4'h0;
  end

  // ==========================================================
  // pins only ever driven towards the unit, never read back
  always @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (level_i[c] !== settled_q[c]) begin
        settled_q[c] <= level_i[c];
        cnt_q[c]     <= bounce_i;
        pin_o[c]     <= level_i[c];
      end else if (cnt_q[c] != 4'h0) begin
        // even count flips the pin, so the last step lands on the new level
        cnt_q[c] <= cnt_q[c] - 4'h1;
        pin_o[c] <= settled_q[c] ^ ~cnt_q[c][0];
      end
    end
  end
endmodule : dcic_pin_model
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench of the dual channel input capture unit
// Assumes: Wishbone answers one cycle after the request is taken
// Notes:   timers held still around every capture
`timescale 1ns/1ps
`default_nettype none
`include "dcic_cfg.svh"
module tb;
  import dcic_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        resetn    = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, bounce = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic        ack;
  logic [15:0] timer_a = 16'h0, timer_b = 16'h0, v;
  logic [1:0]  lvl_req = 2'h0, pins, irq;
  int          err_total = 0, comparisons = 0;
  int          irq_cnt [2] = '{0, 0};

  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) for (int c = 0; c < 2; c++) if (irq[c] === 1'b1) irq_cnt[c]++;

  dcic_pin_model u_pins (.clk_i(clk_sys_i), .level_i(lvl_req), .bounce_i(bounce), .pin_o(pins));
  dcic_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .timer_a_i(timer_a), .timer_b_i(timer_b), .capture_input_0_i(pins[0]),
    .capture_input_1_i(pins[1]), .capture_irq_o(irq));

  // ==========================================================
  // shared helpers
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hF;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("[ERR] %0t bus answer missing", $time);
      summarize();
    end
  endtask : wb

  task automatic rd_latch(input logic [1:0] idx, output logic [15:0] val);
    logic [31:0] lo, hi;
    wb(1'b1, `DCIC_ADR_RDPTR, {30'h0, idx}, lo);
    wb(1'b0, `DCIC_ADR_CAPLO, 32'h0, lo);
    wb(1'b0, `DCIC_ADR_CAPHI, 32'h0, hi);
    val = {hi[7:0], lo[7:0]};
  endtask : rd_latch

  task automatic set_mode(input logic [15:0] m);
    wb(1'b1, `DCIC_ADR_MODE, {16'h0, m}, rd);
    repeat (5) @(posedge clk_sys_i);
    irq_cnt = '{0, 0};
  endtask : set_mode

  task automatic pin(input int c, input logic l, input logic [3:0] b, input int wait_n);
    @(posedge clk_sys_i);
    lvl_req[c] <= l;
    bounce     <= b;
    repeat (wait_n) @(posedge clk_sys_i);
  endtask : pin

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wb(1'b0, `DCIC_ADR_MODE, 32'h0, rd);   chk(rd, 32'h0);
    wb(1'b0, `DCIC_ADR_RDPTR, 32'h0, rd);  chk(rd, 32'h0);
    wb(1'b0, `DCIC_ADR_STATUS, 32'h0, rd); chk(rd, 32'h0);
    wb(1'b1, 8'h18, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h18, 32'h0, rd);            chk(rd, 32'h0);
    rd_latch(2'h3, v);                     chk({16'h0, v}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_swtrig();
    logic [15:0] exp [4];
    set_mode(16'h0100);
    for (int i = 0; i < 4; i++) begin
      exp[i] = (i < 2) ? 16'h1200 + 16'(i) : 16'hAB00 + 16'(i);
      @(posedge clk_sys_i);
      timer_a <= 16'h1200 + 16'(i);
      timer_b <= 16'hAB00 + 16'(i);
      wb(1'b1, `DCIC_ADR_SWTRIG, 32'h1 << i, rd);
      wb(1'b0, `DCIC_ADR_SWTRIG, 32'h0, rd);  chk(rd, 32'h0);
      wb(1'b0, `DCIC_ADR_STATUS, 32'h0, rd);  chk({31'h0, rd[i >> 1]}, {31'h0, i[0]});
      rd_latch(i[1:0], v);                    chk({16'h0, v}, {16'h0, exp[i]});
    end
    rd_latch(2'h0, v);                        chk({16'h0, v}, {16'h0, exp[0]});
    rd_latch(2'h2, v);                        chk({16'h0, v}, {16'h0, exp[2]});
    $display("test software trigger done");
  endtask : t_swtrig

  task automatic t_ch0_fast();
    set_mode(16'h012A);
    @(posedge clk_sys_i) timer_a <= 16'h5A5A;
    pin(0, 1'b1, 4'h3, 20);
    chk(irq_cnt[0], 1);
    wb(1'b0, `DCIC_ADR_STATUS, 32'h0, rd);  chk({30'h0, rd[4], rd[0]}, 32'h2);
    rd_latch(2'h0, v);                      chk({16'h0, v}, 32'h5A5A);
    @(posedge clk_sys_i) timer_a <= 16'hC3C3;
    pin(0, 1'b0, 4'h2, 20);
    chk(irq_cnt[0], 1);
    rd_latch(2'h1, v);                      chk({16'h0, v}, 32'hC3C3);
    rd_latch(2'h0, v);                      chk({16'h0, v}, 32'h5A5A);
    wb(1'b0, `DCIC_ADR_STATUS, 32'h0, rd);  chk({31'h0, rd[0]}, 32'h1);
    set_mode(16'h0126);
    pin(0, 1'b1, 4'h0, 4);
    chk(irq_cnt[0], 1);
    $display("test channel 0 done");
  endtask : t_ch0_fast

  task automatic t_ch1_slow();
    set_mode(16'h3F2A);
    @(posedge clk_sys_i) timer_b <= 16'h0F0F;
    pin(1, 1'b1, 4'h0, 60);
    chk(irq_cnt[1], 0);
    repeat (140) @(posedge clk_sys_i);
    chk(irq_cnt[1], 1);
    rd_latch(2'h2, v);                      chk({16'h0, v}, 32'h0F0F);
    @(posedge clk_sys_i) timer_b <= 16'hF0F0;
    pin(1, 1'b0, 4'h0, 200);
    chk(irq_cnt[1], 2);
    rd_latch(2'h3, v);                      chk({16'h0, v}, 32'hF0F0);
    wb(1'b0, `DCIC_ADR_STATUS, 32'h0, rd);  chk({30'h0, rd[5], rd[1]}, 32'h1);
    set_mode(16'h302A);
    pin(1, 1'b1, 4'h0, 40);
    @(posedge clk_sys_i) timer_a <= 16'h3C3C;
    pin(1, 1'b0, 4'h0, 40);
    chk(irq_cnt[1], 0);
    rd_latch(2'h3, v);                      chk({16'h0, v}, 32'h3C3C);
    $display("test channel 1 done");
  endtask : t_ch1_slow

  initial begin
    repeat (6) @(posedge clk_sys_i);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_swtrig();
    t_ch0_fast();
    t_ch1_slow();
    summarize();
  end
endmodule : tb
`default_nettype wire
